// file: rtl/sbk_pkg.sv
// Purpose: Shared constants of the safe brake control block
// Assumes: 200 MHz clock, 32-bit register port with byte offsets
// Notes: Wait times count in microsecond ticks
package sbk_pkg;
  // Clock and tick timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CU_TIMEOUT_US = 1000;
  localparam int CU_TIMEOUT_TICKS = CU_TIMEOUT_US * 1000 / TICK_PERIOD_NS;
  // Sizes
  localparam int ADDR_W = 8;
  localparam int NUM_DI = 8;
  localparam int NUM_PU = 4;
  localparam int WAIT_W = 16;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FBSRC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WAIT_ON = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WAIT_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PU_INDEX = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CAP = 8'h1C;
  // Configuration fields
  localparam int CFG_ENABLE = 0;
  localparam int CFG_HBC_LO = 1;
  localparam int CFG_ADAPTER = 3;
  localparam int CFG_PARALLEL = 4;
  localparam int CFG_MANUAL = 5;
  localparam int CFG_FB_VIA_PU = 6;
  localparam int CFG_W = 7;
  // Command and status fields
  localparam int CMD_IDENT = 0;
  localparam int ST_RELEASED = 0;
  localparam int ST_CTRL_FAULT = 1;
  localparam int ST_CFG_FAULT = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_IDENT_DONE = 4;
  localparam int ST_CU_LOST = 5;
  localparam int ST_ACTIVE = 6;
  localparam int CAP_PAR_BIT = 14;
  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [WAIT_W-1:0] WAIT_ON_RST = 16'h0064;
  localparam logic [WAIT_W-1:0] WAIT_OFF_RST = 16'h0064;
  // Brake check states
  typedef enum logic [1:0] {SBK_STEADY, SBK_WAIT, SBK_CHECK} sbk_state_t;
endpackage

// file: rtl/sbk_chk_if.sv
// Purpose: Carrier between the brake controller and the path checker
// Assumes: Single clock domain
// Notes: Fault outputs are combinational, sampled on evaluate
`timescale 1ns/1ps
`default_nettype none
interface sbk_chk_if;
  logic wantRelease;
  logic evaluate;
  logic adapterUsed;
  logic compact;
  logic fbLevel;
  logic senseHigh;
  logic senseLow;
  logic currentOk;
  logic pathFault;
  logic breakFault;
  logic fbFault;
  modport ctrl (output wantRelease, evaluate, adapterUsed, compact, fbLevel, senseHigh,
    senseLow, currentOk, input pathFault, breakFault, fbFault);
  modport chk (input wantRelease, evaluate, adapterUsed, compact, fbLevel, senseHigh,
    senseLow, currentOk, output pathFault, breakFault, fbFault);
endinterface
`default_nettype wire

// file: rtl/sbk_path_check.sv
// Purpose: Judges switch paths, winding and adapter feedback after a change
// Assumes: Inputs already synchronised
// Notes: Results only mean something while evaluate is high
`timescale 1ns/1ps
`default_nettype none
module sbk_path_check (
  // Check carrier
  sbk_chk_if.chk c
);
  // Fault decisions, gated by evaluate
  always_comb
  begin
    c.pathFault = c.evaluate
      && ((c.senseHigh != c.wantRelease) || (c.senseLow != c.wantRelease));
    // Winding checks skipped behind an adapter
    // Open brake without current means a broken cable
    c.breakFault = c.evaluate && !c.adapterUsed && c.wantRelease && !c.currentOk;
    // Lingering current after apply means a shorted winding, not on compact units
    if (c.evaluate && !c.adapterUsed && !c.compact && !c.wantRelease && c.currentOk)
    begin
      c.pathFault = 1'b1;
    end
    c.fbFault = c.evaluate && c.adapterUsed && (c.fbLevel != c.wantRelease);
  end
endmodule // sbk_path_check
`default_nettype wire

// file: rtl/sbk_relay_timer.sv
// Purpose: Down-counter for the adapter relay wait time
// Assumes: tick is a one-cycle enable
// Notes: done pulses once, a new load restarts the wait
`timescale 1ns/1ps
`default_nettype none
module sbk_relay_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic armed_q;

  // Count down on ticks while armed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= loadVal;
      armed_q <= 1'b1;
    end
    else if (armed_q && cnt_q == '0)
    begin
      armed_q <= 1'b0;
    end
    else if (armed_q && tick)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = armed_q && (cnt_q == '0) && !load;
endmodule // sbk_relay_timer
`default_nettype wire

// file: rtl/sbk_brake_ctrl.sv
// Purpose: Two-channel safe brake control tied to torque-off
// Assumes: Commands arrive on clk; brake pins pass two flip-flops
// Notes: Any fault forces both switch paths open until cleared
//
// How it works
// - Torque-off selection applies the brake while active
// - Two independent switch outputs cut current
// - Runs whatever the holding brake setting
// - Inactive until enable bit is set
// - Brake selection without torque-off is rejected
// - Paths and winding checked only on change
// - Any brake path fault cuts current
// - Lost control unit heartbeat applies brake
// - Feedback taken from selected digital input
// - Separate wait times for switching on/off
// - Parallel use needs capability bit 14
// - Identification only unconfigured with brake setting 0
// - Single adapter found stores its unit
// - Several adapters found raise configuration fault
// - Identification also sets feedback source input
// - Manual unit without adapter raises control fault in parallel use
// - Cable break reported only when brake controlled
// - Compact variant checks break only opening
// - No winding checks behind an adapter
// - Commands drive brake outputs accordingly
`timescale 1ns/1ps
`default_nettype none
module sbk_brake_ctrl #(
  parameter int NUM_DI = sbk_pkg::NUM_DI,
  parameter int NUM_PU = sbk_pkg::NUM_PU,
  parameter int CU_TIMEOUT_TICKS = sbk_pkg::CU_TIMEOUT_TICKS,
  parameter bit PAR_SUPPORTED = 1'b1,
  parameter bit COMPACT_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [sbk_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Drive-link commands
  input wire logic stoSelect,
  input wire logic brakeSelect,
  input wire logic releaseCmd,
  input wire logic controlAlive,
  // Brake pins
  input wire logic [NUM_DI-1:0] digIn,
  input wire logic [NUM_PU-1:0] adapterPresent,
  input wire logic senseHigh,
  input wire logic senseLow,
  input wire logic currentOk,
  output logic brakeSwitchHigh,
  output logic brakeSwitchLow,
  output logic brakeFault
);
  import sbk_pkg::*;

  localparam int PW = NUM_DI + NUM_PU + 3;
  localparam int DSW = $clog2(NUM_DI);
  localparam int PSW = $clog2(NUM_PU);
  localparam int CW = $clog2(CU_TIMEOUT_TICKS + 1);
  localparam int TW = $clog2(TICK_CYCLES);

  sbk_chk_if chk ();
  sbk_state_t state_q;
  logic [PW-1:0] syncA_q, syncB_q;
  logic [TW-1:0] tickCnt_q;
  logic tick;
  logic [CFG_W-1:0] cfg_q;
  logic [WAIT_W-1:0] waitOn_q, waitOff_q;
  logic [DSW-1:0] fbSrc_q;
  logic [PSW-1:0] puIdx_q;
  logic ctrlFault_q, cfgFault_q, reject_q, identDone_q, cuLost_q;
  logic [CW-1:0] cuCnt_q;
  logic swHigh_q, swLow_q, fault_q;
  logic [31:0] rdata_q;
  logic wantRel_d, change, timerDone, brakeActive, identRun, anyFault;
  logic [NUM_DI-1:0] diSyn;
  logic [NUM_PU-1:0] apSyn;
  logic ctrlSet, cfgSet, statusClr;

  // Number of adapters seen
  function automatic int unsigned countOnes(input logic [NUM_PU-1:0] v);
    int unsigned n;
    n = 0;
    for (int i = 0; i < NUM_PU; i++)
      n = n + int'(v[i]);
    return n;
  endfunction

  // Unit number of the lowest set bit
  function automatic logic [PSW-1:0] firstOne(input logic [NUM_PU-1:0] v);
    logic [PSW-1:0] idx;
    idx = '0;
    for (int i = NUM_PU - 1; i >= 0; i--)
      if (v[i])
        idx = PSW'(i);
    return idx;
  endfunction

  // Two-stage pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      syncA_q <= '0;
      syncB_q <= '0;
    end
    else
    begin
      syncA_q <= {currentOk, senseLow, senseHigh, adapterPresent, digIn};
      syncB_q <= syncA_q;
    end
  end
  assign diSyn = syncB_q[NUM_DI-1:0];
  assign apSyn = syncB_q[NUM_DI +: NUM_PU];

  // Microsecond tick divider
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tickCnt_q <= '0;
    else if (tick)
      tickCnt_q <= '0;
    else
      tickCnt_q <= tickCnt_q + 1'b1;
  end
  assign tick = (tickCnt_q == TW'(TICK_CYCLES - 1));

  // Activation, parallel gate and identification qualifier
  assign brakeActive = cfg_q[CFG_ENABLE] && (!cfg_q[CFG_PARALLEL] || PAR_SUPPORTED);
  assign identRun = regWr && regAddr == OFS_CMD && regWdata[CMD_IDENT]
    && !cfg_q[CFG_ENABLE] && cfg_q[CFG_HBC_LO +: 2] == 2'h0;
  assign anyFault = ctrlFault_q || cfgFault_q;
  assign statusClr = regWr && regAddr == OFS_STATUS;

  // Configuration and wait registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q <= CFG_RST;
      waitOn_q <= WAIT_ON_RST;
      waitOff_q <= WAIT_OFF_RST;
    end
    else if (regWr)
    begin
      if (regAddr == OFS_CFG)
        cfg_q <= regWdata[CFG_W-1:0];
      if (regAddr == OFS_WAIT_ON)
        waitOn_q <= regWdata[WAIT_W-1:0];
      if (regAddr == OFS_WAIT_OFF)
        waitOff_q <= regWdata[WAIT_W-1:0];
    end
  end

  // Feedback source and brake unit, also filled by identification
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fbSrc_q <= '0;
      puIdx_q <= '0;
      identDone_q <= 1'b0;
    end
    else if (identRun)
    begin
      identDone_q <= 1'b1;
      if (countOnes(apSyn) == 1)
      begin
        puIdx_q <= firstOne(apSyn);
        if (cfg_q[CFG_FB_VIA_PU])
          fbSrc_q <= DSW'(firstOne(apSyn));
      end
    end
    else if (regWr)
    begin
      if (regAddr == OFS_FBSRC)
        fbSrc_q <= regWdata[DSW-1:0];
      if (regAddr == OFS_PU_INDEX)
        puIdx_q <= regWdata[PSW-1:0];
    end
  end

  // Control unit heartbeat watchdog
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cuCnt_q <= '0;
      cuLost_q <= 1'b0;
    end
    else if (!brakeActive || controlAlive)
    begin
      cuCnt_q <= '0;
      cuLost_q <= 1'b0;
    end
    else if (cuCnt_q == CW'(CU_TIMEOUT_TICKS))
      cuLost_q <= 1'b1;
    else if (tick)
      cuCnt_q <= cuCnt_q + 1'b1;
  end

  // Desired brake state from commands and faults
  always_comb
  begin
    wantRel_d = releaseCmd;
    if (anyFault)
      wantRel_d = 1'b0;
    if (brakeActive && (stoSelect || cuLost_q))
      wantRel_d = 1'b0;
  end
  assign change = wantRel_d != swHigh_q;

  // Two independent switch channels
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      swHigh_q <= 1'b0;
      swLow_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      swHigh_q <= wantRel_d;
      swLow_q <= wantRel_d;
      fault_q <= anyFault;
    end
  end

  // Relay wait timer, on or off time by direction
  sbk_relay_timer #(.W(WAIT_W)) sbk_relay_timer_inst (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .load(change && brakeActive),
    .loadVal(wantRel_d ? waitOn_q : waitOff_q),
    .done(timerDone)
  );

  // Check sequencer: only state changes are judged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= SBK_STEADY;
    else if (!brakeActive)
      state_q <= SBK_STEADY;
    else if (change)
      state_q <= SBK_WAIT;
    else
    begin
      unique case (state_q)
        SBK_STEADY: state_q <= SBK_STEADY;
        SBK_WAIT: state_q <= timerDone ? SBK_CHECK : SBK_WAIT;
        SBK_CHECK: state_q <= SBK_STEADY;
      endcase
    end
  end

  // Path checker hookup
  assign chk.wantRelease = swHigh_q;
  assign chk.evaluate = state_q == SBK_CHECK;
  assign chk.adapterUsed = cfg_q[CFG_ADAPTER];
  assign chk.compact = COMPACT_VARIANT;
  assign chk.fbLevel = diSyn[fbSrc_q];
  assign chk.senseHigh = syncB_q[PW-3];
  assign chk.senseLow = syncB_q[PW-2];
  assign chk.currentOk = syncB_q[PW-1];
  sbk_path_check sbk_path_check_inst (
    .c(chk.chk)
  );

  // Fault sources
  assign ctrlSet = chk.pathFault || chk.fbFault
    || (chk.evaluate && cfg_q[CFG_PARALLEL] && cfg_q[CFG_MANUAL] && !apSyn[puIdx_q]);
  assign cfgSet = chk.breakFault || (identRun && countOnes(apSyn) > 1);

  // Sticky status, set wins over write-one clear
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrlFault_q <= 1'b0;
      cfgFault_q <= 1'b0;
      reject_q <= 1'b0;
    end
    else
    begin
      if (ctrlSet)
        ctrlFault_q <= 1'b1;
      else if (statusClr && regWdata[ST_CTRL_FAULT])
        ctrlFault_q <= 1'b0;
      if (cfgSet)
        cfgFault_q <= 1'b1;
      else if (statusClr && regWdata[ST_CFG_FAULT])
        cfgFault_q <= 1'b0;
      if (brakeSelect && !stoSelect)
        reject_q <= 1'b1;
      else if (statusClr && regWdata[ST_REJECT])
        reject_q <= 1'b0;
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (!rst_n || !regRd)
      rdata_q <= '0;
    else
    begin
      unique case (regAddr)
        OFS_CFG: rdata_q <= 32'(cfg_q);
        OFS_FBSRC: rdata_q <= 32'(fbSrc_q);
        OFS_WAIT_ON: rdata_q <= 32'(waitOn_q);
        OFS_WAIT_OFF: rdata_q <= 32'(waitOff_q);
        OFS_PU_INDEX: rdata_q <= 32'(puIdx_q);
        OFS_STATUS: rdata_q <= 32'({brakeActive, cuLost_q, identDone_q, reject_q,
          cfgFault_q, ctrlFault_q, swHigh_q});
        OFS_CAP: rdata_q <= 32'(PAR_SUPPORTED) << CAP_PAR_BIT;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign regRdata = rdata_q;
  assign brakeSwitchHigh = swHigh_q;
  assign brakeSwitchLow = swLow_q;
  assign brakeFault = fault_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_change;
    brakeActive && change;
  endsequence

  a_sto_applies: assert property (brakeActive && stoSelect
    |=> !brakeSwitchHigh && !brakeSwitchLow)
    else $error("brake not applied on torque-off");
  a_channels_agree: assert property (brakeSwitchHigh == brakeSwitchLow)
    else $error("switch channels disagree");
  a_inactive_idle: assert property (!brakeActive |=> state_q == SBK_STEADY)
    else $error("check sequencer ran while inactive");
  a_alone_rejected: assert property (brakeSelect && !stoSelect |=> reject_q)
    else $error("lone brake selection not rejected");
  a_check_on_change: assert property (chk.evaluate
    |-> $past(state_q == SBK_WAIT && timerDone))
    else $error("check without a state change");
  a_change_waits: assert property (s_change |=> state_q == SBK_WAIT)
    else $error("change did not start relay wait");
  a_fault_cuts: assert property (ctrlFault_q || cfgFault_q
    |=> !brakeSwitchHigh ##0 brakeFault)
    else $error("fault left brake current on");
  a_cu_lost_applies: assert property (brakeActive && cuLost_q |=> !brakeSwitchLow)
    else $error("lost control unit left brake released");
  a_ident_single: assert property (identRun && countOnes(apSyn) == 1
    |=> puIdx_q == $past(firstOne(apSyn)))
    else $error("identified unit not stored");
  a_ident_multi: assert property (identRun && countOnes(apSyn) > 1 |=> cfgFault_q [*2])
    else $error("several adapters not flagged");
endmodule // sbk_brake_ctrl
`default_nettype wire

// file: verif/sbk_brake_model.sv
// Purpose: Behavioural brake, switch paths and adapter relay at the far side
// Assumes: Switch outputs high mean brake released
// Notes: Defects are injected by the bench, cable break and stuck relay together in the adapter case
`timescale 1ns/1ps
`default_nettype none
module sbk_brake_model #(
  parameter int RELAY_DLY = 100
) (
  // Clock
  input wire logic clk,
  // Switch drive from the block
  input wire logic switchHigh,
  input wire logic switchLow,
  // Injected defects
  input wire logic cableBroken,
  input wire logic stuckOpenHigh,
  input wire logic relayStuck,
  // Readback towards the block
  output logic senseHigh,
  output logic senseLow,
  output logic currentOk,
  output logic relayFb
);
  logic contactQ = 1'b0;
  int relayCnt = 0;

  // Path readback and winding current
  assign senseHigh = switchHigh & ~stuckOpenHigh;
  assign senseLow = switchLow;
  assign currentOk = senseHigh & senseLow & ~cableBroken;
  assign relayFb = contactQ;

  // Single adapter relay contact, lags the switches
  always_ff @(posedge clk)
  begin
    if (relayStuck || ((senseHigh & senseLow) == contactQ))
    begin
      relayCnt <= 0;
    end
    else if (relayCnt >= RELAY_DLY)
    begin
      contactQ <= senseHigh & senseLow;
      relayCnt <= 0;
    end
    else
    begin
      relayCnt <= relayCnt + 1;
    end
  end
endmodule // sbk_brake_model
`default_nettype wire

// file: verif/sbk_brake_ctrl_test.sv
// Purpose: Self-checking bench for the safe brake control block
// Assumes: Wait registers set to 2 us, heartbeat timeout 4 us
// Notes: Fault flags are cleared by a status write between scenarios
`timescale 1ns/1ps
`default_nettype none
module sbk_brake_ctrl_test;
  import sbk_pkg::*;
  localparam int WAITC = 800;
  logic clk, rst_n, regWr, regRd, stoSelect, brakeSelect, releaseCmd, controlAlive;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0] regWdata, regRdata, rdVal;
  logic [7:0] digIn;
  logic [3:0] adapterPresent;
  logic [2:0] fbBit;
  logic senseHigh, senseLow, currentOk, relayFb, swHigh, swLow, brakeFault;
  logic cableBroken, stuckOpenHigh, relayStuck, hbOn;
  int badCount = 0;
  int comparisons = 0;
  int cycles = 0;
  int hbCnt = 0;

  sbk_brake_ctrl #(.CU_TIMEOUT_TICKS(4)) sbk_brake_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .stoSelect(stoSelect), .brakeSelect(brakeSelect),
    .releaseCmd(releaseCmd), .controlAlive(controlAlive), .digIn(digIn),
    .adapterPresent(adapterPresent), .senseHigh(senseHigh), .senseLow(senseLow),
    .currentOk(currentOk), .brakeSwitchHigh(swHigh), .brakeSwitchLow(swLow),
    .brakeFault(brakeFault));
  sbk_brake_model sbk_brake_model_inst (.clk(clk), .switchHigh(swHigh), .switchLow(swLow),
    .cableBroken(cableBroken), .stuckOpenHigh(stuckOpenHigh), .relayStuck(relayStuck),
    .senseHigh(senseHigh), .senseLow(senseLow), .currentOk(currentOk), .relayFb(relayFb));

  // Contact on the chosen input, inverse level elsewhere
  assign digIn = relayFb ? (8'h01 << fbBit) : ~(8'h01 << fbBit);

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Heartbeat and hang guard
  always @(posedge clk)
  begin
    hbCnt <= (hbCnt == 49) ? 0 : hbCnt + 1;
    controlAlive <= hbOn && (hbCnt == 0);
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      badCount++;
      tallyAndFinish();
    end
  end

  task automatic tallyAndFinish();
    $display("Comparisons %0d, mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdVal = regRdata;
    ck(rdVal & m, e);
  endtask

  task automatic sbit(input int b, input logic v);
    rchk(OFS_STATUS, 32'h1 << b, {31'h0, v} << b);
  endtask

  task automatic setRel(input logic v, input int n);
    @(posedge clk);
    releaseCmd <= v;
    repeat (n) @(posedge clk);
  endtask

  task automatic outs(input logic [1:0] e);
    #1 ck({swHigh, swLow}, e);
  endtask

  // Fault output looked at once settled, off the edge
  task automatic fchk(input logic e);
    #1 ck({31'h0, brakeFault}, {31'h0, e});
  endtask

  task automatic settle();
    @(posedge clk);
    {releaseCmd, stoSelect, brakeSelect, cableBroken, stuckOpenHigh, relayStuck} <= '0;
    repeat (WAITC) @(posedge clk);
    wr(OFS_STATUS, 32'hE);
    repeat (4) @(posedge clk);
  endtask

  task automatic tRegs();
    rchk(OFS_CFG, 32'h7F, 32'h0);
    rchk(OFS_WAIT_ON, 32'hFFFF, 32'h64);
    rchk(OFS_WAIT_OFF, 32'hFFFF, 32'h64);
    rchk(OFS_CAP, 32'h4000, 32'h4000);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    wr(OFS_WAIT_ON, 32'h2);
    wr(OFS_WAIT_OFF, 32'h2);
  endtask

  task automatic tInactive();
    cableBroken <= 1'b1;
    setRel(1'b1, 2);
    outs(2'b11);
    sbit(ST_ACTIVE, 1'b0);
    repeat (WAITC) @(posedge clk);
    fchk(1'b0);
    settle();
  endtask

  task automatic tRelease();
    wr(OFS_CFG, 32'h7);
    setRel(1'b1, 2);
    outs(2'b11);
    sbit(ST_RELEASED, 1'b1);
    sbit(ST_ACTIVE, 1'b1);
    repeat (WAITC) @(posedge clk);
    fchk(1'b0);
    @(posedge clk);
    stoSelect <= 1'b1;
    repeat (2) @(posedge clk);
    outs(2'b00);
    sbit(ST_RELEASED, 1'b0);
    settle();
  endtask

  task automatic tReject();
    {stoSelect, brakeSelect} <= 2'b11;
    sbit(ST_REJECT, 1'b0);
    @(posedge clk);
    {stoSelect, brakeSelect} <= 2'b01;
    repeat (2) @(posedge clk);
    sbit(ST_REJECT, 1'b1);
    settle();
    sbit(ST_REJECT, 1'b0);
  endtask

  task automatic tCable();
    setRel(1'b1, WAITC);
    cableBroken <= 1'b1;
    repeat (WAITC) @(posedge clk);
    fchk(1'b0);
    setRel(1'b0, WAITC);
    setRel(1'b1, WAITC);
    sbit(ST_CFG_FAULT, 1'b1);
    outs(2'b00);
    fchk(1'b1);
    settle();
  endtask

  task automatic tStuck();
    stuckOpenHigh <= 1'b1;
    setRel(1'b1, WAITC);
    sbit(ST_CTRL_FAULT, 1'b1);
    outs(2'b00);
    settle();
  endtask

  task automatic tAdapter();
    wr(OFS_CFG, 32'h9);
    wr(OFS_FBSRC, 32'h3);
    fbBit <= 3'h3;
    cableBroken <= 1'b1;
    setRel(1'b1, WAITC);
    setRel(1'b0, WAITC);
    fchk(1'b0);
    relayStuck <= 1'b1;
    setRel(1'b1, WAITC);
    sbit(ST_CTRL_FAULT, 1'b1);
    settle();
  endtask

  task automatic tIdent();
    wr(OFS_CFG, 32'h40);
    adapterPresent <= 4'h4;
    repeat (4) @(posedge clk);
    wr(OFS_CMD, 32'h1);
    repeat (20) @(posedge clk);
    rchk(OFS_PU_INDEX, 32'h3, 32'h2);
    rchk(OFS_FBSRC, 32'h7, 32'h2);
    sbit(ST_IDENT_DONE, 1'b1);
    adapterPresent <= 4'h6;
    repeat (4) @(posedge clk);
    wr(OFS_CMD, 32'h1);
    repeat (20) @(posedge clk);
    sbit(ST_CFG_FAULT, 1'b1);
    wr(OFS_CFG, 32'h41);
    adapterPresent <= 4'h1;
    repeat (4) @(posedge clk);
    wr(OFS_CMD, 32'h1);
    repeat (20) @(posedge clk);
    rchk(OFS_PU_INDEX, 32'h3, 32'h2);
    settle();
  endtask

  task automatic tManual();
    wr(OFS_CFG, 32'h31);
    wr(OFS_PU_INDEX, 32'h1);
    adapterPresent <= 4'h4;
    setRel(1'b1, WAITC);
    sbit(ST_CTRL_FAULT, 1'b1);
    settle();
  endtask

  task automatic tCuLost();
    wr(OFS_CFG, 32'h1);
    setRel(1'b1, WAITC);
    hbOn <= 1'b0;
    repeat (1200) @(posedge clk);
    sbit(ST_CU_LOST, 1'b1);
    outs(2'b00);
  endtask

  // Main sequence
  initial
  begin
    {rst_n, regWr, regRd, stoSelect, brakeSelect, releaseCmd} = '0;
    {cableBroken, stuckOpenHigh, relayStuck} = '0;
    hbOn = 1'b1;
    regAddr = '0;
    regWdata = '0;
    adapterPresent = 4'h0;
    fbBit = 3'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tRegs();
    tInactive();
    tRelease();
    tReject();
    wr(OFS_CFG, 32'h1);
    tCable();
    wr(OFS_CFG, 32'h1);
    tStuck();
    tAdapter();
    tIdent();
    tManual();
    tCuLost();
    tallyAndFinish();
  end
endmodule // sbk_brake_ctrl_test
`default_nettype wire
